// File: rtl/ectimer_defs.vh
`ifndef ECTIMER_DEFS_VH
`define ECTIMER_DEFS_VH
// ****************************************
// register map (byte addresses)
// ****************************************
`define REG_COUNT 4'h0
`define REG_MODE 4'h4
`define REG_START 4'h8
`define REG_STATUS 4'hc
// ****************************************
// mode register fields
// ****************************************
`define MODE_SEL_LO 0
`define MODE_SEL_HI 1
`define MODE_EDGE_LO 2
`define MODE_EDGE_HI 3
`define MODE_MEAS_WIDTH 4
`define MODE_SRC_TIMER 5
`define MODE_CLK_LO 6
`define MODE_CLK_HI 7
// ****************************************
// encodings
// ****************************************
`define OPMODE_TIMER 2'h0
`define OPMODE_EVENT 2'h1
`define OPMODE_MEASURE 2'h2
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_BOTH 2'h2
`define CLKSEL_DIV1 2'h0
`define CLKSEL_DIV8 2'h1
`define CLKSEL_DIV32 2'h2
`define CLKSEL_SUB32 2'h3
// ****************************************
// reset values and divider counts
// ****************************************
`define MODE_RESET 8'h00
`define COUNT_RESET 16'h0000
`define DIV8_COUNT 8
`define DIV32_COUNT 32
`endif

// File: rtl/edge_sync.v
`timescale 1ns/1ps
// two-flop synchroniser with edge select
module edge_sync (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // pin and select
  input wire pin_i,
  input wire rise_en_i,
  input wire fall_en_i,
  // result
  output wire edge_o
);
  reg meta;
  reg sync;
  reg last;
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= pin_i;
      sync <= meta;
      last <= sync;
    end
  end
  assign edge_o = (rise_en_i & sync & ~last) | (fall_en_i & ~sync & last);
endmodule

// File: rtl/clk_prescale.v
`timescale 1ns/1ps
`include "ectimer_defs.vh"
// prescaler: one-cycle ticks of the divided clocks
module clk_prescale (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // subclock tick, one cycle per subclock period
  input wire sub_tick_i,
  input wire [1:0] sel_i,
  // tick out
  output reg tick_o
);
  reg [4:0] div_cnt;
  reg [4:0] sub_cnt;
  always @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= 5'h00;
      sub_cnt <= 5'h00;
    end else begin
      div_cnt <= div_cnt + 5'h01;
      if (sub_tick_i)
        sub_cnt <= sub_cnt + 5'h01;
    end
  end
  always @* begin
    case (sel_i)
      `CLKSEL_DIV1: tick_o = 1'b1;
      `CLKSEL_DIV8: tick_o = (div_cnt[2:0] == 3'h7);
      `CLKSEL_DIV32: tick_o = (div_cnt == 5'h1f);
      `CLKSEL_SUB32: tick_o = sub_tick_i & (sub_cnt == 5'h1f);
      default: tick_o = 1'b0;
    endcase
  end
endmodule

// File: rtl/event_count_pulse_measure_timer.v
`timescale 1ns/1ps
`include "ectimer_defs.vh"
// Operation
// - mode register low two bits pick timer, event count or measurement
// - event mode counts pin edges or another timer's overflow
// - count edge selectable: rising, falling, or both
// - event mode counts down, reloads on underflow, keeps counting
// - reload value n gives one underflow per n+1 events
// - counting runs while start flag is 1, halts at 0
// - event mode requests interrupt on every underflow
// - event mode count read returns live counter
// - write while halted loads reload and counter together
// - write while running loads reload only, counter at next reload
// - measurement counts up, captures to reload on edge, restarts at zero
// - measurement edge requests interrupt, except first edge after start
// - measurement overflow requests interrupt and sets overflow flag
// - mode write while started clears overflow flag
// - measurement count read returns reload register capture
// - measurement result undefined before second edge after start
// - measurement mode ignores count register writes
// - input pin is measured pulse or count source by mode
module event_count_pulse_measure_timer #(
  parameter WIDTH = 16
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // classic wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [3:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // count sources
  input wire count_input_pin_i,
  input wire timer_ovf_i,
  input wire subclk_tick_i,
  // events
  output reg irq_o,
  output reg underflow_o
);
  // ****************************************
  // registers
  // ****************************************
  reg [WIDTH-1:0] counter;
  reg [WIDTH-1:0] reload;
  reg [7:0] mode;
  reg start;
  reg overflow;
  reg first_seen;
  reg second_seen;
  wire [1:0] opmode;
  wire [1:0] edge_sel;
  wire [1:0] clk_sel;
  wire rise_en;
  wire fall_en;
  wire pin_edge;
  wire meas_tick;
  wire is_event;
  wire is_measure;
  wire event_hit;
  wire meas_edge;
  wire acc;
  wire wr;
  wire wr_count;
  wire wr_mode;
  wire wr_start;
  wire cnt_max;

  assign opmode = mode[`MODE_SEL_HI:`MODE_SEL_LO];
  assign edge_sel = mode[`MODE_EDGE_HI:`MODE_EDGE_LO];
  assign clk_sel = mode[`MODE_CLK_HI:`MODE_CLK_LO];
  assign is_event = (opmode == `OPMODE_EVENT);
  assign is_measure = (opmode == `OPMODE_MEASURE);

  // ****************************************
  // edge selection
  // ****************************************
  // event and measurement edge choice
  assign rise_en = is_measure ? (mode[`MODE_MEAS_WIDTH] | (edge_sel != `EDGE_FALL))
                              : ((edge_sel == `EDGE_RISE) | (edge_sel == `EDGE_BOTH));
  assign fall_en = is_measure ? (mode[`MODE_MEAS_WIDTH] | (edge_sel == `EDGE_FALL))
                              : ((edge_sel == `EDGE_FALL) | (edge_sel == `EDGE_BOTH));

  // one pin, role set by mode
  edge_sync u_edge_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(count_input_pin_i),
    .rise_en_i(rise_en),
    .fall_en_i(fall_en),
    .edge_o(pin_edge)
  );

  clk_prescale u_clk_prescale (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sub_tick_i(subclk_tick_i),
    .sel_i(clk_sel),
    .tick_o(meas_tick)
  );

  assign event_hit = mode[`MODE_SRC_TIMER] ? timer_ovf_i : pin_edge;
  assign meas_edge = is_measure & start & pin_edge;
  assign cnt_max = (counter == {WIDTH{1'b1}});

  // ****************************************
  // bus decode
  // ****************************************
  // every access answers in the cycle after strobe; unmapped reads give zero
  // writes land at the edge where the master sees ack, never a cycle early
  assign acc = cyc_i & stb_i & ~ack_o;
  assign wr = cyc_i & stb_i & we_i & ack_o;
  assign wr_count = wr & (adr_i == `REG_COUNT) & sel_i[0];
  assign wr_mode = wr & (adr_i == `REG_MODE) & sel_i[0];
  assign wr_start = wr & (adr_i == `REG_START) & sel_i[0];

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= acc;
      dat_o <= 32'h00000000;
      if (acc & ~we_i) begin
        case (adr_i)
          `REG_COUNT: dat_o[WIDTH-1:0] <= is_measure ? reload : counter;
          `REG_MODE: dat_o[7:0] <= mode;
          `REG_START: dat_o[0] <= start;
          // valid bit marks capture past second edge
          `REG_STATUS: dat_o[1:0] <= {second_seen, overflow};
          default: dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      mode <= `MODE_RESET;
      start <= 1'b0;
    end else begin
      if (wr_mode)
        mode <= dat_i[7:0];
      if (wr_start)
        start <= dat_i[0];
    end
  end

  // ****************************************
  // counter and reload
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      counter <= `COUNT_RESET;
      reload <= `COUNT_RESET;
      underflow_o <= 1'b0;
      irq_o <= 1'b0;
      overflow <= 1'b0;
      first_seen <= 1'b0;
      second_seen <= 1'b0;
    end else begin
      underflow_o <= 1'b0;
      irq_o <= 1'b0;
      if (wr_start & dat_i[0] & ~start) begin
        first_seen <= 1'b0;
        second_seen <= 1'b0;
      end
      if (is_event) begin
        if (wr_count) begin
          reload <= dat_i[WIDTH-1:0];
          if (~start)
            counter <= dat_i[WIDTH-1:0];
        end
        if (start & event_hit) begin
          if (counter == {WIDTH{1'b0}}) begin
            counter <= wr_count ? dat_i[WIDTH-1:0] : reload;
            underflow_o <= 1'b1;
            irq_o <= 1'b1;
          end else begin
            counter <= counter - {{(WIDTH-1){1'b0}}, 1'b1};
          end
        end
      end else if (is_measure) begin
        if (meas_edge) begin
          reload <= counter;
          counter <= `COUNT_RESET;
          first_seen <= 1'b1;
          if (first_seen)
            second_seen <= 1'b1;
          if (first_seen)
            irq_o <= 1'b1;
        end else if (start & meas_tick) begin
          counter <= counter + {{(WIDTH-1){1'b0}}, 1'b1};
          if (cnt_max)
            irq_o <= 1'b1;
        end
      end else begin
        // interval timer: internal count source, down count with reload
        if (wr_count) begin
          reload <= dat_i[WIDTH-1:0];
          if (~start)
            counter <= dat_i[WIDTH-1:0];
        end
        if (start & meas_tick) begin
          if (counter == {WIDTH{1'b0}}) begin
            counter <= reload;
            underflow_o <= 1'b1;
            irq_o <= 1'b1;
          end else begin
            counter <= counter - {{(WIDTH-1){1'b0}}, 1'b1};
          end
        end
      end
      if (is_measure & start & meas_tick & ~meas_edge & cnt_max)
        overflow <= 1'b1;
      else if (wr_mode & start)
        overflow <= 1'b0;
    end
  end
endmodule

// File: test/ectimer_props.sv
`timescale 1ns/1ps
// ****
// bus and event checks
// ****
module ectimer_props (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // bus
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [3:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  // events
  input wire irq_o,
  input wire underflow_o
);
  reg run;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // shadow of start flag, taken at the edge the write lands
  always @(posedge clk_i) begin
    if (rst_i) begin
      run <= 1'b0;
    end else if (cyc_i && stb_i && we_i && ack_o && adr_i == 4'h8 && sel_i[0]) begin
      run <= dat_i[0];
    end
  end
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_ans;
    cyc_i && stb_i && !ack_o |=> ack_o;
  endproperty
  a_ack_ans: assert property (p_ack_ans) else $error("ack late");
  property p_ack_req;
    $rose(ack_o) |-> $past(cyc_i && stb_i);
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack unasked");
  property p_dat_idle;
    !ack_o |-> dat_o == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data idle");
  property p_dat_wr;
    ack_o && we_i |-> dat_o == 32'h0;
  endproperty
  a_dat_wr: assert property (p_dat_wr) else $error("data on write");
  property p_uf_irq;
    underflow_o |-> irq_o;
  endproperty
  a_uf_irq: assert property (p_uf_irq) else $error("underflow irq");
  property p_halt_irq;
    !run [*5] |-> !irq_o;
  endproperty
  a_halt_irq: assert property (p_halt_irq) else $error("irq halted");
  property p_halt_uf;
    !run [*5] |-> !underflow_o;
  endproperty
  a_halt_uf: assert property (p_halt_uf) else $error("underflow halted");
endmodule
bind event_count_pulse_measure_timer ectimer_props ectimer_props_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .sel_i, .dat_i, .dat_o, .ack_o, .irq_o, .underflow_o);

// File: test/pin_model.sv
`timescale 1ns/1ps
// ****
// pulse source on the input pin, idles low
// ****
module pin_model (
  // clock
  input wire clk_i,
  // pin
  output logic pin_o
);
  initial pin_o = 1'b0;
  task automatic pulse(input int n, input int hi, input int lo);
    repeat (n) begin
      @(posedge clk_i);
      pin_o <= 1'b1;
      repeat (hi) @(posedge clk_i);
      pin_o <= 1'b0;
      repeat (lo) @(posedge clk_i);
    end
  endtask
endmodule

// File: test/tb_top.sv
`timescale 1ns/1ps
`include "ectimer_defs.vh"
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [3:0] adr_i = 4'h0;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0;
  logic timer_ovf_i = 1'b0;
  logic subclk_tick_i = 1'b0;
  logic [1:0] sc = 2'h0;
  wire [31:0] dat_o;
  wire ack_o, irq_o, underflow_o, pin;
  int n_fail = 0;
  int check_count = 0;
  int n_irq = 0;
  int n_uf = 0;
  int dv[4] = '{0, 3, 5, 7};
  event_count_pulse_measure_timer event_count_pulse_measure_timer_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .count_input_pin_i(pin), .timer_ovf_i, .subclk_tick_i, .irq_o,
    .underflow_o);
  pin_model pin_model_i (.clk_i, .pin_o(pin));
  always #20 clk_i = ~clk_i;
  // subclock tick every fourth cycle
  always @(posedge clk_i) begin
    sc <= sc + 2'h1;
    subclk_tick_i <= (sc == 2'h3);
    if (irq_o === 1'b1) n_irq++;
    if (underflow_o === 1'b1) n_uf++;
  end
  task automatic finish_test;
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("ERROR %0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [31:0] q);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hf, q);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hf, q);
    check(q, e);
  endtask
  task automatic t_reset;
    wr(4'h1, 32'hff);
    for (int i = 0; i < 5; i++) rchk(i == 4 ? 4'h1 : 4'(i * 4), 32'h0);
  endtask
  // interval mode on the undivided clock: reload 9 gives one underflow per 10 ticks
  task automatic t_timer;
    wr(`REG_MODE, 32'h0);
    wr(`REG_COUNT, 32'h9);
    n_uf = 0;
    wr(`REG_START, 32'h1);
    repeat (100) @(posedge clk_i);
    wr(`REG_START, 32'h0);
    check(n_uf, 32'ha);
  endtask
  task automatic t_edges;
    for (int e = 0; e < 3; e++) begin
      wr(`REG_START, 32'h0);
      wr(`REG_MODE, 32'(e * 4 + 1));
      wr(`REG_COUNT, 32'h64);
      wr(`REG_START, 32'h1);
      pin_model_i.pulse(2, 3, 6);
      rchk(`REG_COUNT, e == 2 ? 32'h60 : 32'h62);
    end
  endtask
  task automatic t_reload;
    logic [31:0] q;
    wr(`REG_START, 32'h0);
    wr(`REG_MODE, 32'h5);
    wr(`REG_COUNT, 32'h2);
    wb(1'b1, `REG_COUNT, 32'h7, 4'he, q);
    rchk(`REG_COUNT, 32'h2);
    n_irq = 0;
    n_uf = 0;
    wr(`REG_START, 32'h1);
    pin_model_i.pulse(1, 3, 6);
    rchk(`REG_COUNT, 32'h1);
    wr(`REG_COUNT, 32'h5);
    rchk(`REG_COUNT, 32'h1);
    pin_model_i.pulse(2, 3, 6);
    rchk(`REG_COUNT, 32'h5);
    pin_model_i.pulse(6, 3, 6);
    check(n_irq, 32'h2);
    check(n_uf, 32'h2);
    wr(`REG_START, 32'h0);
    pin_model_i.pulse(2, 3, 6);
    rchk(`REG_COUNT, 32'h5);
  endtask
  task automatic t_source;
    wr(`REG_MODE, 32'h21);
    wr(`REG_COUNT, 32'h1);
    n_irq = 0;
    wr(`REG_START, 32'h1);
    repeat (4) begin
      @(posedge clk_i);
      timer_ovf_i <= 1'b1;
      @(posedge clk_i);
      timer_ovf_i <= 1'b0;
    end
    pin_model_i.pulse(2, 3, 6);
    check(n_irq, 32'h2);
    wr(`REG_START, 32'h0);
  endtask
  task automatic t_measure;
    logic [31:0] m;
    logic [31:0] e;
    for (int k = 0; k < 4; k++) begin
      e = 32'h100 >> dv[k];
      wr(`REG_START, 32'h0);
      wr(`REG_MODE, {24'h0, 2'(k), 6'h06});
      n_irq = 0;
      wr(`REG_START, 32'h1);
      pin_model_i.pulse(3, 127, 128);
      wb(1'b0, `REG_COUNT, 32'h0, 4'hf, m);
      check({31'h0, m + 32'h1 - e <= 32'h2}, 32'h1);
      check(n_irq, 32'h2);
      wr(`REG_COUNT, 32'h1234);
      rchk(`REG_COUNT, m);
    end
    wr(`REG_START, 32'h0);
  endtask
  // width mode: both polarities capture; then period on falling edges only
  task automatic t_width;
    wr(`REG_MODE, 32'h16);
    n_irq = 0;
    n_uf = 0;
    wr(`REG_START, 32'h1);
    rchk(`REG_STATUS, 32'h0);
    pin_model_i.pulse(2, 63, 128);
    rchk(`REG_COUNT, 32'h3e);
    rchk(`REG_STATUS, 32'h2);
    check(n_irq, 32'h3);
    check(n_uf, 32'h0);
    wr(`REG_START, 32'h0);
    wr(`REG_MODE, 32'h2);
    wr(`REG_START, 32'h1);
    pin_model_i.pulse(2, 63, 128);
    rchk(`REG_COUNT, 32'hbf);
    wr(`REG_START, 32'h0);
  endtask
  task automatic t_overflow;
    logic [31:0] q;
    wr(`REG_MODE, 32'h6);
    n_irq = 0;
    wr(`REG_START, 32'h1);
    repeat (65545) @(posedge clk_i);
    wb(1'b0, `REG_STATUS, 32'h0, 4'hf, q);
    check(q & 32'h1, 32'h1);
    check(n_irq, 32'h1);
    wr(`REG_MODE, 32'h6);
    wb(1'b0, `REG_STATUS, 32'h0, 4'hf, q);
    check(q & 32'h1, 32'h0);
  endtask
  initial begin
    repeat (90000) @(posedge clk_i);
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_timer();
    t_edges();
    t_reload();
    t_source();
    t_measure();
    t_width();
    t_overflow();
    finish_test();
  end
endmodule
